// ===== ccsp_params.svh
// Constants for the converter configuration serial port host
`ifndef CCSP_PARAMS_SVH
`define CCSP_PARAMS_SVH

// ==========================================================
// Frame layout
`define CCSP_INSTR_BITS     5'd16
`define CCSP_WORD_BITS      5'd8
`define CCSP_WL_ONE         2'h0
`define CCSP_WL_TWO         2'h1
`define CCSP_WL_THREE       2'h2
`define CCSP_WL_STREAM      2'h3

// ==========================================================
// Serial clock timing
`define CCSP_CLK_NS         40
`define CCSP_SCLK_HALF_NS   160
`define CCSP_SCLK_HALF_CYC  ((`CCSP_SCLK_HALF_NS + `CCSP_CLK_NS - 1) / `CCSP_CLK_NS)

// ==========================================================
// Device map used by the host
`define CCSP_ADDR_PORT_CFG  13'h0000
`define CCSP_ADDR_CHIP_GRD  13'h0002
`define CCSP_ADDR_CHAN_SEL  13'h0005
`define CCSP_ADDR_ADC_LO    13'h0008
`define CCSP_ADDR_ADC_HI    13'h0020
`define CCSP_ADDR_ADC_EXT   13'h003A
`define CCSP_ADDR_DC_LO     13'h0040
`define CCSP_ADDR_DC_HI     13'h0042
`define CCSP_ADDR_FD_LO     13'h0045
`define CCSP_ADDR_FD_HI     13'h004C
`define CCSP_ADDR_DSP_LO    13'h0050
`define CCSP_ADDR_DSP_HI    13'h005A
`define CCSP_ADDR_XFER      13'h00FF
`define CCSP_XFER_GO        8'h01
`define CCSP_CHAN_A_BIT     0
`define CCSP_CHAN_B_BIT     1
`define CCSP_CHAN_SEL_RST   8'h03

`endif

// ===== ccsp_pkg.sv
// Types shared by the configuration serial port host
package ccsp_pkg;

    // ==========================================================
    // Frame sequencer states, Gray along idle-instr-data-tail
    typedef enum logic [2:0] {
        CCSP_IDLE  = 3'b000,
        CCSP_INSTR = 3'b001,
        CCSP_DATA  = 3'b011,
        CCSP_TAIL  = 3'b010,
        CCSP_STALL = 3'b111
    } ccsp_state_t;

    // ==========================================================
    // User command and read answer
    typedef struct packed {
        logic        read;
        logic [1:0]  word_len;
        logic [12:0] addr;
        logic [7:0]  stream_cnt;
    } ccsp_cmd_t;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } ccsp_rd_t;

endpackage : ccsp_pkg

// ===== ccsp_sclk_gen.sv
// Serial clock divider with rise and fall strobes
`timescale 1ns/100ps
`default_nettype none

module ccsp_sclk_gen #(
    parameter int HALF_DIV = 4
) (
    input  wire logic clk_i,     // System clock
    input  wire logic resetn_i,  // Async reset, active low
    input  wire logic run_i,     // Clock runs while high
    output logic      sclk_o,    // Serial clock level
    output logic      rise_o,    // Pulse: sclk rises next edge
    output logic      fall_o     // Pulse: sclk falls next edge
);

    logic [7:0] cnt;
    wire        tick = run_i && (cnt == 8'(HALF_DIV - 1));

    assign rise_o = tick && !sclk_o;
    assign fall_o = tick && sclk_o;

    // ==========================================================
    // Divider; parks low when stopped so no stray edge leaves
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt    <= 8'h00;
            sclk_o <= 1'b0;
        end else if (!run_i) begin
            cnt    <= 8'h00;
            sclk_o <= 1'b0;
        end else if (tick) begin
            cnt    <= 8'h00;
            sclk_o <= ~sclk_o;
        end else begin
            cnt    <= cnt + 8'h01;
        end
    end

endmodule : ccsp_sclk_gen

`default_nettype wire

// ===== ccsp_host.sv
// Host controller driving the converter's three-wire configuration port
`timescale 1ns/100ps
`default_nettype none
`include "ccsp_params.svh"

module ccsp_host
    import ccsp_pkg::*;
#(
    parameter int HALF_DIV = `CCSP_SCLK_HALF_CYC
) (
    input  wire logic                clk_i,         // System clock, 25 MHz
    input  wire logic                resetn_i,      // Async reset, active low
    input  wire logic                port_en_i,     // Port in use
    input  wire logic                lsb_first_i,   // Device set to LSB first
    input  wire logic                cmd_valid_i,   // Command offered
    output logic                     cmd_ready_o,   // Command accepted
    input  wire ccsp_pkg::ccsp_cmd_t cmd_i,         // Command fields
    output logic                     cmd_err_o,     // Pulse: command refused
    input  wire logic                wdata_valid_i, // Write byte offered
    output logic                     wdata_ready_o, // Write byte taken
    input  wire logic [7:0]          wdata_i,       // Write byte
    output logic                     rd_valid_o,    // Pulse: read byte ready
    output ccsp_pkg::ccsp_rd_t       rd_o,          // Read byte and last flag
    output logic                     busy_o,        // Frame in progress
    output logic                     sclk_o,        // Serial clock pin
    output logic                     select_n_o,    // Chip select pin, low active
    output logic                     sdio_o,        // Data pin drive value
    output logic                     sdio_oe_o,     // Data pin drive enable
    input  wire logic                sdio_i         // Data pin level
);

    import ccsp_pkg::*;

    // ==========================================================
    // Helpers
    function automatic logic addr_ok(input logic [12:0] a);
        addr_ok = (a <= `CCSP_ADDR_CHIP_GRD) || (a == `CCSP_ADDR_CHAN_SEL)
               || (a >= `CCSP_ADDR_ADC_LO && a <= `CCSP_ADDR_ADC_HI)
               || (a == `CCSP_ADDR_ADC_EXT)
               || (a >= `CCSP_ADDR_DC_LO && a <= `CCSP_ADDR_DC_HI)
               || (a >= `CCSP_ADDR_FD_LO && a <= `CCSP_ADDR_FD_HI)
               || (a >= `CCSP_ADDR_DSP_LO && a <= `CCSP_ADDR_DSP_HI)
               || (a == `CCSP_ADDR_XFER);
    endfunction : addr_ok

    function automatic logic [8:0] byte_count(input logic [1:0] wl, input logic [7:0] sc);
        unique case (wl)
            `CCSP_WL_ONE:   byte_count = 9'h001;
            `CCSP_WL_TWO:   byte_count = 9'h002;
            `CCSP_WL_THREE: byte_count = 9'h003;
            // streaming length taken from the user count
            default:        byte_count = {1'b0, sc} + 9'h001;
        endcase
    endfunction : byte_count

    function automatic logic out_bit(input logic [15:0] s, input logic lsb);
        out_bit = lsb ? s[0] : s[15];
    endfunction : out_bit

    // ==========================================================
    // State
    ccsp_state_t state;
    ccsp_state_t next_state;
    logic [15:0] shreg;
    logic [15:0] next_shreg;
    logic [7:0]  rx;
    logic [4:0]  bitcnt;
    logic [8:0]  left;
    logic        rd_q;
    logic        lsb_q;
    logic [7:0]  gap;
    logic        sdio_meta;
    logic        sdio_sync;
    logic        sclk_rise;
    logic        sclk_fall;

    // ==========================================================
    // Decode
    // clock runs only inside a frame
    // Gated by port_en_i so an abort parks the clock low together with select
    wire       run       = port_en_i && ((state == CCSP_INSTR) || (state == CCSP_DATA));
    wire [4:0] unit_bits = (state == CCSP_INSTR) ? `CCSP_INSTR_BITS : `CCSP_WORD_BITS;
    wire       unit_end  = sclk_fall && (bitcnt == unit_bits);
    wire       gap_ok    = gap >= 8'(HALF_DIV);
    // writes outside the device map refused
    wire       cmd_bad   = !cmd_i.read && !addr_ok(cmd_i.addr);
    // reads never refused; caller sets one channel first
    wire       cmd_take  = cmd_valid_i && cmd_ready_o;
    wire       cmd_go    = cmd_take && !cmd_bad;
    wire       lsb_sel   = cmd_go ? lsb_first_i : lsb_q;
    wire       rd_sel    = cmd_go ? cmd_i.read : rd_q;
    wire       need_byte = !rd_q && (((state == CCSP_INSTR) && unit_end)
                        || ((state == CCSP_DATA) && unit_end && (left > 9'h001))
                        || ((state == CCSP_STALL) && gap_ok));
    wire       take_byte = need_byte && wdata_valid_i;
    // user bytes go out as given, unused bits zero
    // byte placed where the chosen order sends it first
    wire [15:0] byte_load = lsb_q ? {8'h00, wdata_i} : {wdata_i, 8'h00};
    wire [15:0] shifted   = lsb_q ? {1'b0, shreg[15:1]} : {shreg[14:0], 1'b0};

    // disabled port never starts a frame
    assign cmd_ready_o   = (state == CCSP_IDLE) && gap_ok && port_en_i;
    assign wdata_ready_o = need_byte;
    assign busy_o        = (state != CCSP_IDLE);

    // first rise comes a half period after select falls
    ccsp_sclk_gen #(
        .HALF_DIV (HALF_DIV)
    ) u_sclk (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .run_i    (run),
        .sclk_o   (sclk_o),
        .rise_o   (sclk_rise),
        .fall_o   (sclk_fall)
    );

    // ==========================================================
    // Next state
    always_comb begin
        next_state = state;
        unique case (state)
            CCSP_IDLE: begin
                if (cmd_go) begin
                    next_state = CCSP_INSTR;
                end
            end
            CCSP_INSTR, CCSP_DATA: begin
                if (unit_end) begin
                    if ((state == CCSP_DATA) && (left == 9'h001)) begin
                        next_state = CCSP_TAIL;
                    // no byte ready: stall with select high
                    end else if (!rd_q && !wdata_valid_i) begin
                        next_state = CCSP_STALL;
                    end else begin
                        next_state = CCSP_DATA;
                    end
                end
            end
            CCSP_STALL: begin
                if (take_byte) begin
                    next_state = CCSP_DATA;
                end
            end
            CCSP_TAIL: begin
                if (gap_ok) begin
                    next_state = CCSP_IDLE;
                end
            end
            default: next_state = CCSP_IDLE;
        endcase
    end

    // ==========================================================
    // Shift register next value
    always_comb begin
        next_shreg = shreg;
        if (cmd_go) begin
            // read flag first, then word length, then address
            next_shreg = {cmd_i.read, cmd_i.word_len, cmd_i.addr};
        end else if (take_byte) begin
            next_shreg = byte_load;
        end else if (run && sclk_fall && !unit_end) begin
            next_shreg = shifted;
        end
    end

    // ==========================================================
    // Input synchroniser for the data pin
    // A half period of four cycles leaves room for these two stages
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sdio_meta <= 1'b0;
            sdio_sync <= 1'b0;
        end else begin
            sdio_meta <= sdio_i;
            sdio_sync <= sdio_meta;
        end
    end

    // ==========================================================
    // Sequencer
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= CCSP_IDLE;
            shreg <= 16'h0000;
            lsb_q <= 1'b0;
            rd_q  <= 1'b0;
        end else begin
            state <= port_en_i ? next_state : CCSP_IDLE;
            shreg <= next_shreg;
            if (cmd_go) begin
                lsb_q <= lsb_first_i;
                rd_q  <= cmd_i.read;
            end
        end
    end

    // Bit count within the current unit; cleared on any unit boundary
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bitcnt <= 5'h00;
        end else if (cmd_go || unit_end || !run) begin
            bitcnt <= 5'h00;
        end else if (sclk_rise) begin
            bitcnt <= bitcnt + 5'h01;
        end
    end

    // bytes remaining from the word length field
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            left <= 9'h000;
        end else if (cmd_go) begin
            left <= byte_count(cmd_i.word_len, cmd_i.stream_cnt);
        end else if ((state == CCSP_DATA) && unit_end) begin
            left <= left - 9'h001;
        end
    end

    // Select-high and clock-still time, before resume or a new frame
    // Starts saturated so the first command after reset is taken at once
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            gap <= 8'hFF;
        end else if (run || ((state == CCSP_TAIL) && gap_ok)) begin
            gap <= 8'h00;
        end else if (!gap_ok) begin
            gap <= gap + 8'h01;
        end
    end

    // read bits sampled on the rising serial clock
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx <= 8'h00;
        end else if ((state == CCSP_DATA) && rd_q && sclk_rise) begin
            rx <= lsb_q ? {sdio_sync, rx[7:1]} : {rx[6:0], sdio_sync};
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_valid_o <= 1'b0;
            rd_o       <= '0;
            cmd_err_o  <= 1'b0;
        end else begin
            rd_valid_o <= (state == CCSP_DATA) && rd_q && unit_end;
            if ((state == CCSP_DATA) && rd_q && unit_end) begin
                rd_o <= '{data: rx, last: (left == 9'h001)};
            end
            cmd_err_o  <= cmd_take && cmd_bad;
        end
    end

    // ==========================================================
    // Pins
    // Driven from next_state so the pins move on the same edge as state
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            select_n_o <= 1'b1;
            sdio_o     <= 1'b0;
            sdio_oe_o  <= 1'b0;
        end else begin
            // select low only while a frame runs
            select_n_o <= !port_en_i || !((next_state == CCSP_INSTR)
                       || (next_state == CCSP_DATA) || (next_state == CCSP_TAIL));
            // leading bit by the captured order
            sdio_o     <= out_bit(next_shreg, lsb_sel);
            // drive the line only for the instruction and write data, not in readback, stall, tail or idle
            sdio_oe_o  <= port_en_i && ((next_state == CCSP_INSTR)
                       || ((next_state == CCSP_DATA) && !rd_sel));
        end
    end

endmodule : ccsp_host

`default_nettype wire

// ===== ccsp_host_assertions.sv
// Concurrent checks on the configuration port host's pins
`timescale 1ns/100ps
`default_nettype none
module ccsp_host_assertions
    import ccsp_pkg::*;
#(
    parameter int HALF_DIV = 4
) (
    input wire logic                clk_i,         // System clock
    input wire logic                resetn_i,      // Async reset, active low
    input wire logic                port_en_i,     // Port in use
    input wire logic                lsb_first_i,   // LSB first order
    input wire logic                cmd_valid_i,   // Command offered
    input wire logic                cmd_ready_o,   // Command accepted
    input wire ccsp_pkg::ccsp_cmd_t cmd_i,         // Command fields
    input wire logic                cmd_err_o,     // Command refused
    input wire logic                wdata_ready_o, // Write byte taken
    input wire logic                rd_valid_o,    // Read byte ready
    input wire logic                busy_o,        // Frame in progress
    input wire logic                sclk_o,        // Serial clock pin
    input wire logic                select_n_o,    // Chip select pin
    input wire logic                sdio_o,        // Data drive value
    input wire logic                sdio_oe_o      // Data drive enable
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // Cycles since the serial clock last moved, saturating
    int hcnt;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) hcnt <= 255;
        else if ($changed(sclk_o)) hcnt <= 0;
        else if (hcnt < 255) hcnt <= hcnt + 1;
    end
    // ==========================================================
    // Assertions
    AST_DISABLED: assert property (!port_en_i && !$past(port_en_i) |-> select_n_o && !sdio_oe_o)
        else $error("disabled port still active");
    AST_START: assert property (
        cmd_valid_i && cmd_ready_o && cmd_i.read && port_en_i |=> !select_n_o && busy_o)
        else $error("read command did not open a frame");
    AST_FIRST_BIT: assert property (
        cmd_valid_i && cmd_ready_o && !lsb_first_i && port_en_i
        |=> cmd_err_o != (sdio_oe_o && sdio_o == $past(cmd_i.read)))
        else $error("first bit is not the direction flag");
    AST_FIRST_RISE: assert property ($fell(select_n_o) |-> ##[1:8] $rose(sclk_o))
        else $error("no clock rise after select fall");
    AST_REFUSED: assert property (cmd_err_o |-> select_n_o && !busy_o)
        else $error("refused command started a frame");
    AST_SCLK_STILL: assert property (select_n_o |-> !sclk_o)
        else $error("serial clock moves outside a frame");
    AST_HALF: assert property ($changed(sclk_o) |-> hcnt >= HALF_DIV - 1)
        else $error("serial clock half period too short");
    AST_OE_SEL: assert property (sdio_oe_o |-> !select_n_o)
        else $error("data line driven while deselected");
    AST_RD_OE: assert property (rd_valid_o |-> !sdio_oe_o)
        else $error("host drove data line in readback");
    AST_RD_PULSE: assert property (rd_valid_o |=> !rd_valid_o)
        else $error("read pulse longer than one cycle");
    AST_WR_BOUND: assert property (wdata_ready_o |-> busy_o && (sclk_o != select_n_o))
        else $error("write byte taken off a byte boundary");
    COV_ERR: cover property (cmd_err_o);
    COV_READ: cover property (rd_valid_o);
    COV_STALL: cover property (wdata_ready_o && select_n_o);
endmodule : ccsp_host_assertions
`default_nettype wire

// ===== ccsp_dev_model.sv
// Behavioural model of the converter's configuration port
`timescale 1ns/100ps
`default_nettype none
module ccsp_dev_model (
    input  wire logic sclk_i,     // Serial clock from host
    input  wire logic select_n_i, // Chip select, low active
    input  wire logic sdio_i,     // Data line level
    output logic      sdio_o,     // Data drive value
    output logic      sdio_oe_o   // Data drive enable
);
    logic [7:0]  act_a [256], act_b [256], shd_a [256], shd_b [256];
    logic [7:0]  port_cfg, chan_sel, sh;
    logic [15:0] ins;
    logic [12:0] addr;
    int          nb;
    wire         lsb = port_cfg[6];
    initial begin
        foreach (act_a[i]) begin
            act_a[i] = 8'h00;
            act_b[i] = 8'h00;
            shd_a[i] = 8'h00;
            shd_b[i] = 8'h00;
        end
        port_cfg = 8'h18;
        chan_sel = 8'h03;
        nb = 0;
        ins = 16'h0000;
        sdio_o = 1'b0;
        sdio_oe_o = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (a == 8'h00) port_cfg = d;
        else if (a == 8'h05) chan_sel = d;
        else if (a == 8'hFF) begin
            if (d[0]) begin
                act_a = shd_a;
                act_b = shd_b;
            end
        end else begin
            if (chan_sel[0]) shd_a[a] = d;
            if (chan_sel[1]) shd_b[a] = d;
        end
    endtask : wr
    // Transfer bit reads cleared, channel A wins
    function automatic logic [7:0] rdv(input logic [7:0] a);
        if (a == 8'h00) return port_cfg;
        if (a == 8'h05) return chan_sel;
        if (a == 8'hFF) return 8'h00;
        return chan_sel[0] ? shd_a[a] : shd_b[a];
    endfunction : rdv
    always @(posedge sclk_i) begin
        if (!select_n_i) begin
            if (nb < 16) ins = lsb ? {sdio_i, ins[15:1]} : {ins[14:0], sdio_i};
            else if (!ins[15]) sh = lsb ? {sdio_i, sh[7:1]} : {sh[6:0], sdio_i};
            nb = nb + 1;
            if (nb == 16) addr = ins[12:0];
            if (nb > 16 && nb % 8 == 0 && !ins[15]) begin
                wr(addr[7:0], sh);
                addr = lsb ? addr + 13'h0001 : addr - 13'h0001;
            end
        end
    end
    // Drive read data after the instruction
    always @(negedge sclk_i) begin
        if (!select_n_i && ins[15] && nb >= 16) begin
            if (nb % 8 == 0) begin
                sh = rdv(addr[7:0]);
                addr = lsb ? addr + 13'h0001 : addr - 13'h0001;
            end
            sdio_o = lsb ? sh[nb % 8] : sh[7 - nb % 8];
            sdio_oe_o = 1'b1;
        end
    end
    // Release line; a stall keeps a one- to three-byte frame, a streamed frame restarts
    always @(posedge select_n_i) begin
        sdio_oe_o = 1'b0;
        if (nb < 16 || ins[14:13] == 2'h3 || nb >= 16 + 8 * (ins[14:13] + 1)) nb = 0;
    end
endmodule : ccsp_dev_model
`default_nettype wire

// ===== tb.sv
// Self-checking testbench for the configuration port host
`timescale 1ns/100ps
`default_nettype none
module tb;
    import ccsp_pkg::*;
    logic       clk_i = 1'b0;
    logic       resetn_i = 1'b0;
    logic       port_en_i = 1'b1;
    logic       lsb_first_i = 1'b0;
    logic       cmd_valid_i = 1'b0;
    ccsp_cmd_t  cmd_i = '0;
    logic       wdata_valid_i = 1'b0;
    logic [7:0] wdata_i = 8'h00;
    logic       cmd_ready_o, cmd_err_o, wdata_ready_o, rd_valid_o, busy_o;
    ccsp_rd_t   rd_o;
    logic       sclk_o, select_n_o, sdio_o, sdio_oe_o, dev_d, dev_oe;
    logic       last_lvl = 1'b0;
    logic [8:0] got [$];
    int         error_cnt = 0;
    int         n_checks = 0;
    int         cyc = 0;
    // Undriven line shows a level that changes every cycle
    wire        sdio_w = sdio_oe_o ? sdio_o : (dev_oe ? dev_d : ~last_lvl);
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) last_lvl <= sdio_w;
    ccsp_host #(.HALF_DIV(4)) ccsp_host_inst (.clk_i(clk_i), .resetn_i(resetn_i),
        .port_en_i(port_en_i), .lsb_first_i(lsb_first_i), .cmd_valid_i(cmd_valid_i),
        .cmd_ready_o(cmd_ready_o), .cmd_i(cmd_i), .cmd_err_o(cmd_err_o),
        .wdata_valid_i(wdata_valid_i), .wdata_ready_o(wdata_ready_o), .wdata_i(wdata_i),
        .rd_valid_o(rd_valid_o), .rd_o(rd_o), .busy_o(busy_o), .sclk_o(sclk_o),
        .select_n_o(select_n_o), .sdio_o(sdio_o), .sdio_oe_o(sdio_oe_o), .sdio_i(sdio_w));
    ccsp_dev_model ccsp_dev_model_inst (.sclk_i(sclk_o), .select_n_i(select_n_o),
        .sdio_i(sdio_w), .sdio_o(dev_d), .sdio_oe_o(dev_oe));
    // ==========================================================
    // Tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic send(input logic rd, input logic [1:0] wl, input logic [12:0] a,
                        input logic [7:0] cnt);
        @(negedge clk_i);
        cmd_valid_i = 1'b1;
        cmd_i = '{read: rd, word_len: wl, addr: a, stream_cnt: cnt};
        while (cmd_ready_o !== 1'b1) @(negedge clk_i);
        @(negedge clk_i);
        cmd_valid_i = 1'b0;
    endtask : send
    // Bytes are offered late by stall cycles to force a select-high pause
    task automatic wr(input logic [12:0] a, input logic [1:0] wl, input logic [7:0] d [$],
                      input int stall);
        send(1'b0, wl, a, 8'h00);
        repeat (stall) @(negedge clk_i);
        foreach (d[i]) begin
            wdata_i = d[i];
            wdata_valid_i = 1'b1;
            while (wdata_ready_o !== 1'b1) @(negedge clk_i);
            @(negedge clk_i);
        end
        wdata_valid_i = 1'b0;
        while (busy_o !== 1'b0) @(negedge clk_i);
    endtask : wr
    task automatic rd(input logic [1:0] wl, input logic [12:0] a, input logic [7:0] cnt);
        got.delete();
        send(1'b1, wl, a, cnt);
        while (busy_o !== 1'b0) begin
            @(negedge clk_i);
            if (rd_valid_o === 1'b1) got.push_back(rd_o);
        end
    endtask : rd
    task automatic rd1(input logic [12:0] a, input logic [7:0] exp);
        rd(2'h0, a, 8'h00);
        chk(8'(got.size()), 8'h01);
        chk(got[0][8:1], exp);
        chk({7'h00, got[0][0]}, 8'h01);
    endtask : rd1
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    // ==========================================================
    // Main sequence; channel writes keep unused bits zero
    initial begin
        repeat (5) @(negedge clk_i);
        resetn_i = 1'b1;
        rd1(13'h0000, 8'h18);
        rd1(13'h0005, 8'h03);
        wr(13'h0047, 2'h0, {8'hA5}, 0);
        chk(ccsp_dev_model_inst.act_a[8'h47], 8'h00);
        wr(13'h00FF, 2'h0, {8'h01}, 0);
        chk(ccsp_dev_model_inst.act_a[8'h47], 8'hA5);
        chk(ccsp_dev_model_inst.act_b[8'h47], 8'hA5);
        rd1(13'h00FF, 8'h00);
        wr(13'h0005, 2'h0, {8'h02}, 0);
        wr(13'h0047, 2'h0, {8'h3C}, 300);
        wr(13'h0005, 2'h0, {8'h01}, 0);
        rd1(13'h0047, 8'hA5);
        wr(13'h0005, 2'h0, {8'h03}, 0);
        rd1(13'h0047, 8'hA5);
        wr(13'h0005, 2'h0, {8'h02}, 0);
        rd1(13'h0047, 8'h3C);
        wr(13'h0049, 2'h1, {8'h11, 8'h22}, 0);
        // Two, three and streamed bytes; the third one is the channel B copy at 0x47
        for (int w = 1; w <= 3; w++) begin
            rd(w[1:0], 13'h0049, 8'h01);
            chk(8'(got.size()), (w == 2) ? 8'h03 : 8'h02);
            chk(got[0][8:1], 8'h11);
            chk(got[1][8:1], 8'h22);
            if (w == 2) begin
                chk(got[2][8:1], 8'h3C);
            end
            chk({7'h00, got[$][0]}, 8'h01);
        end
        send(1'b0, 2'h0, 13'h0030, 8'h00);
        chk({7'h00, cmd_err_o}, 8'h01);
        chk({7'h00, busy_o}, 8'h00);
        wr(13'h0000, 2'h0, {8'h5A}, 0);
        lsb_first_i = 1'b1;
        rd1(13'h0049, 8'h11);
        rd1(13'h0000, 8'h5A);
        port_en_i = 1'b0;
        repeat (3) @(negedge clk_i);
        chk({7'h00, select_n_o}, 8'h01);
        chk({7'h00, sdio_oe_o}, 8'h00);
        tally_and_finish();
    end
endmodule : tb
bind ccsp_host ccsp_host_assertions #(.HALF_DIV(HALF_DIV)) chk_inst (.clk_i(clk_i),
    .resetn_i(resetn_i), .port_en_i(port_en_i), .lsb_first_i(lsb_first_i),
    .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_i(cmd_i),
    .cmd_err_o(cmd_err_o), .wdata_ready_o(wdata_ready_o), .rd_valid_o(rd_valid_o),
    .busy_o(busy_o), .sclk_o(sclk_o), .select_n_o(select_n_o), .sdio_o(sdio_o),
    .sdio_oe_o(sdio_oe_o));
`default_nettype wire
